/* File: logic/timer_cmp_map.svh */
`ifndef TIMER_CMP_MAP_SVH
`define TIMER_CMP_MAP_SVH

// Register offsets
`define ADDR_COMPARE_B      6'h21
`define ADDR_COMPARE_A      6'h22
`define ADDR_FLAGS          6'h25
`define ADDR_MASK           6'h26
`define ADDR_COUNT_LOW      6'h23
`define ADDR_COUNT_HIGH     6'h27
`define ADDR_TIMER_CTRL     6'h24
`define ADDR_PRESCALE_CTRL  6'h18

// Field positions
`define BIT_CAPTURE         7
`define BIT_RESERVED        6
`define BIT_COMPARE_B       5
`define BIT_COMPARE_A       4
`define BIT_OVERFLOW        3
`define BIT_WIDE            7
`define BIT_CAPTURE_MODE    6
`define BIT_TOP_CAPTURE     3
`define BIT_SYNC_HOLD       5
`define BIT_PRESCALE_RESET  4

// Reset values
`define RESET_BYTE          8'h00
`define RESET_PRESCALE      10'h000

// Fixed mask of writable flag and enable bits
`define FLAG_MASK           8'hbf

`endif

/* File: logic/timer_cmp_pkg.sv */
package timer_cmp_pkg;
    typedef enum logic [2:0] {
        CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
    } clock_sel_t;
    typedef logic [7:0] byte_t;
endpackage

/* File: logic/ext_pin_sync.sv */
`timescale 1ns/1ps
`include "timer_cmp_map.svh"
module ext_pin_sync
(
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic nrst_in,
    // Pin and select
    input  wire logic pin_in,
    input  wire logic rise_sel_in,
    // Count pulse
    output logic      pulse_out
);
    logic sample;
    logic synced;
    logic last;
    logic next_pulse;

    // Sample, then edge detect on the synchronised level
    always_comb
    begin
        next_pulse = rise_sel_in ? (synced & ~last) : (~synced & last);
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sample    <= 1'b0;
            synced    <= 1'b0;
            last      <= 1'b0;
            pulse_out <= 1'b0;
        end
        else
        begin
            sample    <= pin_in;
            synced    <= sample;
            last      <= synced;
            pulse_out <= next_pulse;
        end
    end
endmodule

/* File: logic/timer_compare_flags_prescaler.sv */
`timescale 1ns/1ps
`include "timer_cmp_map.svh"
module timer_compare_flags_prescaler
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       nrst_in,
    // Register port
    input  wire logic [5:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic      [7:0] reg_rdata_out,
    // Timer side
    input  wire logic [2:0] clock_select_in,
    input  wire logic [2:0] other_clock_select_in,
    input  wire logic [15:0] counter_in,
    input  wire logic       wide_mode_select_in,
    input  wire logic       capture_mode_in,
    input  wire logic       capture_top_in,
    input  wire logic       capture_event_in,
    input  wire logic       overflow_in,
    input  wire logic       external_count_pin_in,
    input  wire logic       global_irq_enable_in,
    input  wire logic [3:0] vector_ack_in,
    // Outputs
    output logic            count_tick_out,
    output logic            other_count_tick_out,
    output logic            timers_halted_out,
    output logic [3:0]      irq_out,
    output logic [15:0]     compare_value_out
);
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] temp_high;
    logic [7:0] timer_interrupt_flags;
    logic [7:0] timer_interrupt_mask;
    logic       sync_hold_mode;
    logic       prescaler_reset_bit;
    logic [9:0] prescale_count;
    logic       pin_pulse;
    logic       last_counter_valid;
    logic [15:0] last_counter;

    logic [7:0] next_compare_a_value;
    logic [7:0] next_compare_b_value;
    logic [7:0] next_temp_high;
    logic [7:0] next_flags;
    logic [7:0] next_mask;
    logic       next_sync_hold_mode;
    logic       next_prescaler_reset_bit;
    logic [9:0] next_prescale_count;
    logic [7:0] next_rdata;
    logic       next_tick;
    logic       next_other_tick;
    logic [3:0] next_irq;
    logic       match_a;
    logic       match_b;
    logic [7:0] set_bits;
    logic [7:0] clear_bits;

    // Tick for a select code from the shared prescaler, or from the synchronised pin pulse for the external codes
    function automatic logic tick_for(input logic [2:0] sel, input logic [9:0] cnt,
                                      input logic pin, input logic halt);
        logic t;
        t = 1'b0;
        unique case (timer_cmp_pkg::clock_sel_t'(sel))
            timer_cmp_pkg::CS_STOP:     t = 1'b0;
            timer_cmp_pkg::CS_DIV1:     t = ~halt;
            timer_cmp_pkg::CS_DIV8:     t = ~halt & (cnt[2:0] == 3'h7);
            timer_cmp_pkg::CS_DIV64:    t = ~halt & (cnt[5:0] == 6'h3f);
            timer_cmp_pkg::CS_DIV256:   t = ~halt & (cnt[7:0] == 8'hff);
            timer_cmp_pkg::CS_DIV1024:  t = ~halt & (cnt == 10'h3ff);
            timer_cmp_pkg::CS_EXT_FALL: t = pin;
            timer_cmp_pkg::CS_EXT_RISE: t = pin;
        endcase
        return t;
    endfunction

    // ----------------------------------------
    // External pin
    // ----------------------------------------
    ext_pin_sync u_pin
    (
        .mclk_in     (mclk_in),
        .nrst_in     (nrst_in),
        .pin_in      (external_count_pin_in),
        .rise_sel_in (clock_select_in[0]),
        .pulse_out   (pin_pulse)
    );

    // ----------------------------------------
    // Registers, flags and prescaler
    // ----------------------------------------
    always_comb
    begin
        next_compare_a_value     = compare_a_value;
        next_compare_b_value     = compare_b_value;
        next_temp_high           = temp_high;
        next_mask                = timer_interrupt_mask;
        next_sync_hold_mode      = sync_hold_mode;
        next_prescaler_reset_bit = prescaler_reset_bit & sync_hold_mode;
        clear_bits               = `RESET_BYTE;
        if (reg_write_in)
        begin
            unique case (reg_addr_in)
                `ADDR_COMPARE_A:
                begin
                    next_compare_a_value = reg_wdata_in;
                    if (wide_mode_select_in)
                        next_compare_b_value = temp_high;
                end
                `ADDR_COMPARE_B:
                begin
                    if (wide_mode_select_in)
                        next_temp_high = reg_wdata_in;
                    else
                        next_compare_b_value = reg_wdata_in;
                end
                `ADDR_COUNT_HIGH: next_temp_high = reg_wdata_in;
                `ADDR_MASK:       next_mask = reg_wdata_in & `FLAG_MASK;
                `ADDR_FLAGS:      clear_bits = reg_wdata_in & `FLAG_MASK;
                `ADDR_PRESCALE_CTRL:
                begin
                    next_sync_hold_mode      = reg_wdata_in[`BIT_SYNC_HOLD];
                    next_prescaler_reset_bit = reg_wdata_in[`BIT_PRESCALE_RESET]
                                               & reg_wdata_in[`BIT_SYNC_HOLD];
                end
                default: ;
            endcase
        end
        clear_bits[`BIT_CAPTURE]   = clear_bits[`BIT_CAPTURE]   | vector_ack_in[3];
        clear_bits[`BIT_COMPARE_B] = clear_bits[`BIT_COMPARE_B] | vector_ack_in[2];
        clear_bits[`BIT_COMPARE_A] = clear_bits[`BIT_COMPARE_A] | vector_ack_in[1];
        clear_bits[`BIT_OVERFLOW]  = clear_bits[`BIT_OVERFLOW]  | vector_ack_in[0];

        // Compare match on each new counter value
        match_a = wide_mode_select_in
                ? (counter_in == {compare_b_value, compare_a_value})
                : (counter_in[7:0] == compare_a_value);
        match_b = ~wide_mode_select_in
                & (counter_in[7:0] == compare_b_value);
        if (!last_counter_valid || counter_in == last_counter)
        begin
            match_a = 1'b0;
            match_b = 1'b0;
        end
        set_bits = `RESET_BYTE;
        set_bits[`BIT_CAPTURE]   = capture_event_in
                                   | (capture_top_in & counter_in[7:0] == compare_a_value
                                      & ~wide_mode_select_in);
        set_bits[`BIT_COMPARE_B] = match_b;
        set_bits[`BIT_COMPARE_A] = match_a & ~capture_mode_in;
        set_bits[`BIT_OVERFLOW]  = overflow_in;
        next_flags = (timer_interrupt_flags & ~clear_bits) | set_bits;

        // Free running divider, only the reset bit restarts it
        if (prescaler_reset_bit || (reg_write_in && reg_addr_in == `ADDR_PRESCALE_CTRL
                                    && reg_wdata_in[`BIT_PRESCALE_RESET]))
            next_prescale_count = `RESET_PRESCALE;
        else
            next_prescale_count = prescale_count + 10'h001;

        next_tick       = tick_for(clock_select_in, prescale_count, pin_pulse,
                                   prescaler_reset_bit);
        next_other_tick = tick_for(other_clock_select_in, prescale_count, 1'b0,
                                   prescaler_reset_bit);

        next_irq = {4{global_irq_enable_in}} &
                   {timer_interrupt_flags[`BIT_CAPTURE]   & timer_interrupt_mask[`BIT_CAPTURE],
                    timer_interrupt_flags[`BIT_COMPARE_B] & timer_interrupt_mask[`BIT_COMPARE_B],
                    timer_interrupt_flags[`BIT_COMPARE_A] & timer_interrupt_mask[`BIT_COMPARE_A],
                    timer_interrupt_flags[`BIT_OVERFLOW]  & timer_interrupt_mask[`BIT_OVERFLOW]};
        next_rdata = reg_rdata_out;
        if (reg_read_in)
        begin
            unique case (reg_addr_in)
                `ADDR_COMPARE_A:     next_rdata = compare_a_value;
                `ADDR_COMPARE_B:     next_rdata = compare_b_value;
                `ADDR_FLAGS:         next_rdata = timer_interrupt_flags;
                `ADDR_MASK:          next_rdata = timer_interrupt_mask;
                `ADDR_PRESCALE_CTRL: next_rdata = {2'b00, sync_hold_mode,
                                                   prescaler_reset_bit, 4'h0};
                default:             next_rdata = `RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            compare_a_value       <= `RESET_BYTE;
            compare_b_value       <= `RESET_BYTE;
            temp_high             <= `RESET_BYTE;
            timer_interrupt_flags <= `RESET_BYTE;
            timer_interrupt_mask  <= `RESET_BYTE;
            sync_hold_mode        <= 1'b0;
            prescaler_reset_bit   <= 1'b0;
            prescale_count        <= `RESET_PRESCALE;
            last_counter          <= 16'h0000;
            last_counter_valid    <= 1'b0;
            reg_rdata_out         <= `RESET_BYTE;
            count_tick_out        <= 1'b0;
            other_count_tick_out  <= 1'b0;
            timers_halted_out     <= 1'b0;
            irq_out               <= 4'h0;
            compare_value_out     <= 16'h0000;
        end
        else
        begin
            compare_a_value       <= next_compare_a_value;
            compare_b_value       <= next_compare_b_value;
            temp_high             <= next_temp_high;
            timer_interrupt_flags <= next_flags;
            timer_interrupt_mask  <= next_mask;
            sync_hold_mode        <= next_sync_hold_mode;
            prescaler_reset_bit   <= next_prescaler_reset_bit;
            prescale_count        <= next_prescale_count;
            last_counter          <= counter_in;
            last_counter_valid    <= 1'b1;
            reg_rdata_out         <= next_rdata;
            count_tick_out        <= next_tick;
            other_count_tick_out  <= next_other_tick;
            timers_halted_out     <= next_prescaler_reset_bit;
            irq_out               <= next_irq;
            compare_value_out     <= {next_compare_b_value, next_compare_a_value};
        end
    end
endmodule

/* File: testbench/pin_source.sv */
`timescale 1ns/1ps
module pin_source
#(
    parameter int HALF_NS = 17
)
(
    // Control
    input  wire logic run_in,
    // Count pin
    output logic      pin_out
);
    initial pin_out = 1'b0;
    // Toggles while running and at most once more after run_in drops, otherwise held still
    always
    begin
        wait (run_in);
        #(HALF_NS);
        pin_out = ~pin_out;
    end
endmodule

/* File: testbench/timer_compare_flags_prescaler_chk.sv */
`timescale 1ns/1ps
`include "timer_cmp_map.svh"
module timer_compare_flags_prescaler_chk
(
    // Watched ports
    input wire logic        mclk_in,
    input wire logic        nrst_in,
    input wire logic [5:0]  reg_addr_in,
    input wire logic        reg_write_in,
    input wire logic        reg_read_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [2:0]  clock_select_in,
    input wire logic        wide_mode_select_in,
    input wire logic        external_count_pin_in,
    input wire logic        global_irq_enable_in,
    input wire logic        count_tick_out,
    input wire logic        timers_halted_out,
    input wire logic [3:0]  irq_out,
    input wire logic [15:0] compare_value_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    stop_sel_a:
        assert property (clock_select_in == 3'h0 && $past(clock_select_in) == 3'h0
            && $past(clock_select_in, 2) == 3'h0 |-> !count_tick_out) else $error("tick stopped");
    div1_tick_a:
        assert property (clock_select_in == 3'h1 && $past(clock_select_in) == 3'h1
            && !timers_halted_out && !$past(timers_halted_out) |-> count_tick_out)
            else $error("undivided tick missing");
    div8_gap_a:
        assert property (count_tick_out && clock_select_in == 3'h2 |=> !count_tick_out [*7])
            else $error("divide by 8 gap wrong");
    irq_gate_a:
        assert property (|irq_out |-> $past(global_irq_enable_in)) else $error("irq without gie");
    cmp_src_a:
        assert property ($changed(compare_value_out) |-> $past(reg_write_in))
            else $error("compare changed without write");
    wide_load_a:
        assert property (reg_write_in && reg_addr_in == `ADDR_COMPARE_B && wide_mode_select_in
            |=> $stable(compare_value_out)) else $error("high byte loaded early");
    rsvd_bit_a:
        assert property (reg_read_in && (reg_addr_in == `ADDR_FLAGS || reg_addr_in == `ADDR_MASK)
            |=> ##1 !reg_rdata_out[6]) else $error("reserved bit set");
    pin_edge_a:
        assert property ($rose(external_count_pin_in) && clock_select_in == 3'h7
            |-> ##[2:6] count_tick_out) else $error("pin edge not counted");
    cover property (irq_out[1]);
    cover property (count_tick_out && clock_select_in == 3'h7);
    cover property (timers_halted_out);
endmodule
bind timer_compare_flags_prescaler timer_compare_flags_prescaler_chk chk_i (.mclk_in, .nrst_in,
    .reg_addr_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .clock_select_in,
    .wide_mode_select_in, .external_count_pin_in, .global_irq_enable_in, .count_tick_out,
    .timers_halted_out, .irq_out, .compare_value_out);

/* File: testbench/timer_compare_flags_prescaler_test.sv */
`timescale 1ns/1ps
module timer_compare_flags_prescaler_test;
    typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic        mclk_in = 0;
    logic        nrst_in = 0;
    logic [5:0]  addr = 0;
    logic [7:0]  wdata = 0;
    logic        wr_en = 0;
    logic        rd_en = 0;
    logic [2:0]  sel = 0;
    logic [15:0] cnt = 0;
    logic        wide = 0;
    logic        cap_mode = 0;
    logic        cap_ev = 0;
    logic        cap_top = 0;
    logic        ovf = 0;
    logic        run = 0;
    logic        gie = 0;
    logic [3:0]  ack = 0;
    logic        pin, tick, otick, halted;
    logic [7:0]  rdata, r;
    logic [3:0]  irq;
    logic [15:0] cmpv;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          n_tick, n_otick, n_rise, n_fall, cycles;
    int          tw[6] = '{64, 64, 64, 128, 512, 2048};
    int          te[6] = '{0, 64, 8, 2, 2, 2};
    row_t        rows[6] = '{'{6'h21, 8'ha5, 8'ha5}, '{6'h22, 8'h5a, 8'h5a},
        '{6'h26, 8'hff, 8'hbf}, '{6'h25, 8'h40, 8'h00}, '{6'h00, 8'h3c, 8'h00},
        '{6'h26, 8'h10, 8'h10}};
    always #2.5 mclk_in = ~mclk_in;
    pin_source src (.run_in(run), .pin_out(pin));
    timer_compare_flags_prescaler uut (.mclk_in, .nrst_in, .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata),
        .clock_select_in(sel), .other_clock_select_in(3'h2), .counter_in(cnt),
        .wide_mode_select_in(wide), .capture_mode_in(cap_mode), .capture_top_in(cap_top),
        .capture_event_in(cap_ev), .overflow_in(ovf), .external_count_pin_in(pin),
        .global_irq_enable_in(gie), .vector_ack_in(ack), .count_tick_out(tick),
        .other_count_tick_out(otick), .timers_halted_out(halted), .irq_out(irq),
        .compare_value_out(cmpv));
    // -----------------
    // Counters and tasks
    // -----------------
    always @(posedge mclk_in)
    begin
        cycles++;
        n_tick += int'(tick === 1'b1);
        n_otick += int'(otick === 1'b1);
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    always @(posedge pin) n_rise++;
    always @(negedge pin) n_fall++;
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        {addr, wdata, wr_en} = {a, d, 1'b1};
        @(negedge mclk_in);
        wr_en = 0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
        @(negedge mclk_in);
        {addr, rd_en} = {a, 1'b1};
        @(negedge mclk_in);
        rd_en = 0;
        @(negedge mclk_in);
        chk(n, {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic settle(input logic [15:0] c);
        @(negedge mclk_in);
        cnt = c;
        repeat (4) @(negedge mclk_in);
    endtask
    task automatic win(input int w);
        @(negedge mclk_in);
        {n_tick, n_otick, n_rise, n_fall} = '0;
        repeat (w) @(negedge mclk_in);
    endtask
    // -----------------
    // Sequence
    // -----------------
    initial
    begin
        repeat (5) @(negedge mclk_in);
        nrst_in = 1;
        foreach (rows[i]) rd(rows[i].a, 8'h00, "reset value");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e, "register");
        end
        chk("compare pair", 16'ha55a, cmpv);
        settle(16'h005a);
        rd(6'h25, 8'h10, "flag A");
        gie = 1;
        settle(16'h005a);
        chk("irq A", 4'h2, {12'h000, irq});
        gie = 0;
        settle(16'h005a);
        chk("irq off", 4'h0, {12'h000, irq});
        wr(6'h25, 8'h00);
        rd(6'h25, 8'h10, "zero write");
        wr(6'h25, 8'h10);
        rd(6'h25, 8'h00, "one write");
        settle(16'h00a5);
        rd(6'h25, 8'h20, "flag B");
        ack = 4'h4;
        @(negedge mclk_in) ack = 0;
        rd(6'h25, 8'h00, "vector clear");
        cap_top = 1;
        settle(16'h015a);
        rd(6'h25, 8'h90, "top capture");
        cap_top = 0;
        wr(6'h25, 8'hff);
        rd(6'h25, 8'h00, "top cleared");
        {ovf, cap_ev} = 2'b11;
        @(negedge mclk_in) {ovf, cap_ev} = 2'b00;
        rd(6'h25, 8'h88, "ovf capture");
        wr(6'h25, 8'hff);
        wide = 1;
        wr(6'h21, 8'h12);
        chk("temp held", 16'ha55a, cmpv);
        wr(6'h22, 8'h34);
        chk("wide load", 16'h1234, cmpv);
        settle(16'h0012);
        settle(16'h0034);
        rd(6'h25, 8'h00, "wide no match");
        settle(16'h1234);
        rd(6'h25, 8'h10, "wide match");
        wr(6'h25, 8'h10);
        wide = 0;
        cap_mode = 1;
        settle(16'h0134);
        rd(6'h25, 8'h00, "capture mode");
        cap_mode = 0;
        for (int i = 0; i < 6; i++)
        begin
            sel = 3'(i);
            win(tw[i]);
            chk("tap ticks", 16'(te[i]), 16'(n_tick));
            chk("other ticks", 16'(tw[i] / 8), 16'(n_otick));
        end
        wr(6'h18, 8'h30);
        win(20);
        chk("held ticks", 16'h0000, 16'(n_tick));
        chk("halted", 16'h0001, {15'h0000, halted});
        wr(6'h18, 8'h00);
        repeat (3) @(negedge mclk_in);
        chk("released", 16'h0000, {15'h0000, halted});
        wr(6'h18, 8'h10);
        repeat (3) @(negedge mclk_in);
        chk("self clear", 16'h0000, {15'h0000, halted});
        for (int s = 6; s < 8; s++)
        begin
            sel = 3'(s);
            win(4);
            run = 1;
            #600 run = 0;
            repeat (12) @(negedge mclk_in);
            chk("pin ticks", 16'(s == 7 ? n_rise : n_fall), 16'(n_tick));
        end
        give_verdict();
    end
endmodule
